// ### src/pmdl_pkg.sv
// Package for the peripheral disable lock bank: offsets, masks, resets.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
package pmdl_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned NUM_REGS = 6;
    // Register word offsets, one per disable register
    localparam logic [15:0] OFS_ANALOG = 16'hf240;
    localparam logic [15:0] OFS_COMPARATOR = 16'hf250;
    localparam logic [15:0] OFS_CAPTURE = 16'hf260;
    localparam logic [15:0] OFS_TIMER = 16'hf270;
    localparam logic [15:0] OFS_SERIAL = 16'hf280;
    localparam logic [15:0] OFS_MISC = 16'hf290;
    localparam logic [15:0] OFS_STEP = 16'h0010;
    // Alias offsets within each register slot
    localparam logic [3:0] ALIAS_PLAIN = 4'h0;
    localparam logic [3:0] ALIAS_CLR = 4'h4;
    localparam logic [3:0] ALIAS_SET = 4'h8;
    localparam logic [3:0] ALIAS_INV = 4'hc;
    // Config control register holding the lock bit, and its bit position
    localparam logic [15:0] OFS_CFG_CTRL = 16'hf200;
    localparam int unsigned LOCK_BIT = 12;
    // Unlock key register and the two-word key
    localparam logic [15:0] OFS_KEY = 16'hf230;
    localparam logic [31:0] KEY_FIRST = 32'haa99_6655;
    localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;
    // Position of the one-shot fuse in config word three
    localparam int unsigned FUSE_BIT = 28;
    // Implemented bits per register
    localparam logic [31:0] MASK_ANALOG = 32'h0000_1101;
    localparam logic [31:0] MASK_COMPARATOR = 32'h0000_0007;
    localparam logic [31:0] MASK_CAPTURE = 32'h001f_001f;
    localparam logic [31:0] MASK_TIMER = 32'h0000_001f;
    localparam logic [31:0] MASK_SERIAL = 32'h0103_0303;
    localparam logic [31:0] MASK_MISC = 32'h0001_0003;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    typedef enum logic [1:0] {
        PMDL_KEY_IDLE,
        PMDL_KEY_HALF,
        PMDL_KEY_OPEN
    } pmdl_key_e;
endpackage : pmdl_pkg

// ### src/pmdl_bank.sv
// Peripheral module disable register bank with lock and one-shot fuse.
// Assumes an Avalon-MM master on clk_sys and a fuse word stable after reset.
`timescale 1ns/1ps
`default_nettype none
module pmdl_bank #(
    parameter int unsigned NREG = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [pmdl_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [31:0] config_word_three,
    output logic [NREG*32-1:0] module_clk_gate_n
);
    import pmdl_pkg::*;

    // Refused at elaboration: the decode serves exactly six slots
    generate
        if (NREG != NUM_REGS) begin : g_bad_nreg
            $error("pmdl_bank serves exactly six registers");
        end
    endgenerate

    localparam logic [31:0] MASKS [NUM_REGS] = '{MASK_ANALOG, MASK_COMPARATOR,
        MASK_CAPTURE, MASK_TIMER, MASK_SERIAL, MASK_MISC};

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    logic [31:0] disable_ff [NUM_REGS];
    logic disable_reg_lock_bit_ff;
    logic fuse_ff;
    logic fuse_taken_ff;
    logic lock_set_once_ff;
    pmdl_key_e key_ff;
    pmdl_key_e nxt_key;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [NREG*32-1:0] gate_ff;

    // Slave answers on the next enabled edge after the request; waitrequest low until the following enabled edge
    wire logic req = (avs_read || avs_write) && !ack_ff;
    wire logic wr_go = avs_write && ack_ff;
    wire logic rd_go = avs_read && !ack_ff;
    wire logic [31:0] wmask = be_mask(avs_byteenable);
    wire logic [15:0] slot_base = {avs_address[15:4], 4'h0};
    wire logic [3:0] alias_sel = avs_address[3:0];
    wire logic [15:0] slot_off = slot_base - OFS_ANALOG;
    wire logic in_bank = (slot_base >= OFS_ANALOG) && (slot_base <= OFS_MISC);
    wire logic [2:0] slot_idx = slot_off[6:4];
    wire logic hit_cfg = slot_base == OFS_CFG_CTRL;
    wire logic hit_key = avs_address == OFS_KEY;
    wire logic [31:0] wd = avs_writedata & wmask;
    wire logic key_open = key_ff == PMDL_KEY_OPEN;
    wire logic lock_clr_block = fuse_ff && lock_set_once_ff;
    wire logic [31:0] cfg_now = {19'h0_0000, disable_reg_lock_bit_ff, 12'h000};
    logic [31:0] cfg_new;
    always_comb begin
        cfg_new = cfg_now;
        case (alias_sel)
            ALIAS_PLAIN: cfg_new = (cfg_now & ~wmask) | wd;
            ALIAS_CLR: cfg_new = cfg_now & ~wd;
            ALIAS_SET: cfg_new = cfg_now | wd;
            ALIAS_INV: cfg_new = cfg_now ^ wd;
            default: cfg_new = cfg_now;
        endcase
    end
    wire logic cfg_wr = wr_go && hit_cfg && key_open;
    wire logic lock_want = cfg_new[LOCK_BIT];
    wire logic nxt_lock = (lock_clr_block && !lock_want) ? 1'b1 : lock_want;

    always_comb begin
        nxt_key = key_ff;
        if (wr_go && hit_key) begin
            case (key_ff)
                PMDL_KEY_IDLE: nxt_key = (avs_writedata == KEY_FIRST && !lock_clr_block)
                    ? PMDL_KEY_HALF : PMDL_KEY_IDLE;
                PMDL_KEY_HALF: nxt_key = (avs_writedata == KEY_SECOND) ? PMDL_KEY_OPEN
                    : PMDL_KEY_IDLE;
                default: nxt_key = PMDL_KEY_IDLE;
            endcase
        end else if (wr_go && !hit_key && key_ff == PMDL_KEY_HALF) begin
            nxt_key = PMDL_KEY_IDLE;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_bank && alias_sel == ALIAS_PLAIN) begin
            rd_mux = disable_ff[slot_idx];
        end else if (hit_cfg && alias_sel == ALIAS_PLAIN) begin
            rd_mux = cfg_now;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_ff <= req;
            if (rd_go) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // fuse captured after reset; once set with fuse, lock only reset clears
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fuse_taken_ff <= 1'b0;
            fuse_ff <= 1'b0;
            disable_reg_lock_bit_ff <= 1'b0;
            lock_set_once_ff <= 1'b0;
            key_ff <= PMDL_KEY_IDLE;
        end else if (clk_en) begin
            if (!fuse_taken_ff) begin
                fuse_ff <= config_word_three[FUSE_BIT];
                fuse_taken_ff <= 1'b1;
            end
            key_ff <= cfg_wr ? PMDL_KEY_IDLE : nxt_key;
            if (cfg_wr) begin
                disable_reg_lock_bit_ff <= nxt_lock;
                if (nxt_lock) begin
                    lock_set_once_ff <= 1'b1;
                end
            end
        end
    end

    // alias write effect, lock suppresses it
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            logic [31:0] nxt_val;
            always_comb begin
                nxt_val = disable_ff[g];
                case (alias_sel)
                    ALIAS_PLAIN: nxt_val = (disable_ff[g] & ~wmask) | wd;
                    ALIAS_CLR: nxt_val = disable_ff[g] & ~wd;
                    ALIAS_SET: nxt_val = disable_ff[g] | wd;
                    ALIAS_INV: nxt_val = disable_ff[g] ^ wd;
                    default: nxt_val = disable_ff[g];
                endcase
            end
            // reset to zero, unimplemented bits held zero
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    disable_ff[g] <= RESET_VAL;
                end else if (clk_en && wr_go && in_bank && slot_idx == 3'(g)
                        && !disable_reg_lock_bit_ff) begin
                    disable_ff[g] <= nxt_val & MASKS[g];
                end
            end
            // clock gate enable low when disabled
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    gate_ff[g*32 +: 32] <= {32{1'b1}};
                end else if (clk_en) begin
                    gate_ff[g*32 +: 32] <= ~disable_ff[g] | ~MASKS[g];
                end
            end
            gate_slot_a: assert property (@(posedge clk_sys) disable iff (rst)
                clk_en |=> gate_ff[g*32 +: 32] == ~($past(disable_ff[g]) & MASKS[g]))
                else $error("module gate out of step with disable bits");
            mask_slot_a: assert property (@(posedge clk_sys) disable iff (rst)
                (disable_ff[g] & ~MASKS[g]) == 32'h0000_0000)
                else $error("unimplemented bit set in slot");
        end
    endgenerate

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = !ack_ff;
    assign module_clk_gate_n = gate_ff;

    locked_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && wr_go && in_bank && disable_reg_lock_bit_ff)
        |=> $stable(disable_ff[slot_idx]))
        else $error("disable register changed while locked");
    // no clear after set with fuse
    fuse_lock_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (fuse_ff && disable_reg_lock_bit_ff) |=> disable_reg_lock_bit_ff)
        else $error("fuse-held lock was cleared");
    key_refused_a: assert property (@(posedge clk_sys) disable iff (rst)
        (lock_clr_block && key_ff == PMDL_KEY_IDLE) |=> key_ff == PMDL_KEY_IDLE)
        else $error("unlock key advanced while locked");
    unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        in_bank |-> (disable_ff[slot_idx] & ~MASKS[slot_idx]) == 32'h0000_0000)
        else $error("unimplemented bit set");
    sequence s_lock_move;
        ##1 (disable_reg_lock_bit_ff != $past(disable_reg_lock_bit_ff));
    endsequence
    lock_keyed_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!(clk_en && cfg_wr)) |-> not s_lock_move)
        else $error("lock changed without key");
    gate_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && disable_ff[0][0]) |=> !gate_ff[0])
        else $error("gate not closed for disabled module");
    set_alias_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && wr_go && in_bank && slot_idx == 3'd3 && alias_sel == ALIAS_SET
        && !disable_reg_lock_bit_ff) |=> ((disable_ff[3] & $past(wd) & MASK_TIMER)
        == ($past(wd) & MASK_TIMER)))
        else $error("set alias failed");
    answer_time_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && req) |=> !avs_waitrequest)
        else $error("bus answer late");
    // fuse lock stays through the next two cycles
    fuse_reset_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        lock_clr_block |=> lock_clr_block [*2])
        else $error("fuse lock dropped without reset");
    sequence s_open_wr;
        clk_en && wr_go && in_bank && !disable_reg_lock_bit_ff;
    endsequence
    clr_alias_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_open_wr ##0 (alias_sel == ALIAS_CLR))
        |=> (disable_ff[$past(slot_idx)] & $past(wd)) == 32'h0000_0000)
        else $error("clear alias failed");
    inv_alias_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_open_wr ##0 (alias_sel == ALIAS_INV))
        |=> disable_ff[$past(slot_idx)]
        == (($past(disable_ff[slot_idx]) ^ $past(wd)) & MASKS[$past(slot_idx)]))
        else $error("invert alias failed");
    plain_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_open_wr ##0 (alias_sel == ALIAS_PLAIN))
        |=> disable_ff[$past(slot_idx)] == ((($past(disable_ff[slot_idx])
        & ~$past(wmask)) | $past(wd)) & MASKS[$past(slot_idx)]))
        else $error("plain write failed");
    cfg_keyless_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && wr_go && hit_cfg && !key_open) |=> $stable(disable_reg_lock_bit_ff))
        else $error("lock moved without key");
    // key good for one config control write only
    key_closes_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && cfg_wr) |=> key_ff == PMDL_KEY_IDLE)
        else $error("key stayed open after config write");
    fuse_fixed_a: assert property (@(posedge clk_sys) disable iff (rst)
        fuse_taken_ff |=> $stable(fuse_ff))
        else $error("fuse value moved after capture");
    lock_reset_a: assert property (@(posedge clk_sys)
        rst |=> !disable_reg_lock_bit_ff && !lock_set_once_ff)
        else $error("lock survived reset");
    lock_once_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && cfg_wr && nxt_lock) |=> lock_set_once_ff)
        else $error("lock set not remembered");
    // Held enable low freezes state
    freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
        !clk_en |=> $stable(disable_reg_lock_bit_ff) && $stable(key_ff) && $stable(ack_ff))
        else $error("state moved while enable low");
    // waitrequest low for one enabled cycle only; it stays low while clk_en is held low
    wait_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && ack_ff) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    read_data_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && rd_go) |=> avs_readdata == $past(rd_mux))
        else $error("read data wrong");
    unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && rd_go && !in_bank && !hit_cfg) |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : pmdl_bank
`default_nettype wire

// ### test/pmdl_tb.sv
// Self-checking bench for the peripheral disable lock bank.
// Drives the Avalon-MM slave directly; fuse word is a plain input.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmdl_pkg::*;
    logic clk_sys, rst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, config_word_three, rd;
    logic [3:0] avs_byteenable;
    logic [191:0] module_clk_gate_n;
    int n_mismatch = 0;
    int checks = 0;
    logic [31:0] masks [6] = '{MASK_ANALOG, MASK_COMPARATOR, MASK_CAPTURE, MASK_TIMER,
        MASK_SERIAL, MASK_MISC};
    pmdl_bank #(.NREG(6)) dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .config_word_three(config_word_three), .module_clk_gate_n(module_clk_gate_n));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic summarize();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    function automatic logic [15:0] adr(input int i, input logic [3:0] al);
        return OFS_ANALOG + OFS_STEP * 16'(i) + {12'h000, al};
    endfunction : adr
    // Holds the request until waitrequest is sampled low; bounded wait
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        if (k == 100) begin
            n_mismatch++;
            summarize();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    // Sampled mid-cycle so the gate update after the ack has landed
    task automatic gate(input int i, input logic [31:0] v);
        @(negedge clk_sys);
        chk(module_clk_gate_n[32*i +: 32], ~v);
        @(posedge clk_sys);
    endtask : gate
    task automatic do_reset(input logic fuse);
        rst <= 1'b1;
        config_word_three <= fuse ? 32'h1000_0000 : 32'h0000_0000;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask : do_reset
    task automatic set_lock(input logic v);
        bus(1'b1, OFS_KEY, KEY_FIRST);
        bus(1'b1, OFS_KEY, KEY_SECOND);
        bus(1'b1, OFS_CFG_CTRL, {19'h0_0000, v, 12'h000});
    endtask : set_lock
    task automatic lock_is(input logic v);
        bus(1'b0, OFS_CFG_CTRL, 32'h0000_0000);
        chk({31'h0000_0000, rd[LOCK_BIT]}, {31'h0000_0000, v});
    endtask : lock_is
    task automatic t_reset();
        do_reset(1'b0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, adr(i, ALIAS_PLAIN), 32'h0000_0000);
            chk(rd, RESET_VAL);
            gate(i, 32'h0000_0000);
        end
        bus(1'b0, 16'hf2a0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset_values done");
    endtask : t_reset
    task automatic t_plain();
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, adr(i, ALIAS_PLAIN), 32'hffff_ffff);
            bus(1'b0, adr(i, ALIAS_PLAIN), 32'h0000_0000);
            chk(rd, masks[i]);
            gate(i, masks[i]);
            bus(1'b1, adr(i, ALIAS_PLAIN), 32'h0000_0000);
            gate(i, 32'h0000_0000);
        end
        $display("test plain_writes done");
    endtask : t_plain
    task automatic t_alias();
        bus(1'b1, adr(4, ALIAS_PLAIN), 32'h0000_0300);
        bus(1'b1, adr(4, ALIAS_SET), 32'h0100_0001);
        bus(1'b0, adr(4, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0100_0301);
        bus(1'b1, adr(4, ALIAS_CLR), 32'h0000_0200);
        bus(1'b0, adr(4, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0100_0101);
        bus(1'b1, adr(4, ALIAS_INV), 32'h8003_0101);
        bus(1'b0, adr(4, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0103_0000);
        gate(4, 32'h0103_0000);
        bus(1'b1, adr(3, ALIAS_SET), 32'hffff_0005);
        avs_byteenable <= 4'h1;
        bus(1'b1, adr(3, ALIAS_PLAIN), 32'hffff_ff02);
        avs_byteenable <= 4'hf;
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        bus(1'b0, adr(3, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        $display("test alias_writes done");
    endtask : t_alias
    task automatic t_lock();
        bus(1'b1, adr(0, ALIAS_PLAIN), 32'h0000_0000);
        set_lock(1'b1);
        lock_is(1'b1);
        bus(1'b1, adr(0, ALIAS_PLAIN), 32'hffff_ffff);
        bus(1'b1, adr(0, ALIAS_SET), 32'hffff_ffff);
        bus(1'b0, adr(0, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, OFS_CFG_CTRL, 32'h0000_0000);
        lock_is(1'b1);
        set_lock(1'b0);
        lock_is(1'b0);
        bus(1'b1, adr(0, ALIAS_PLAIN), 32'hffff_ffff);
        bus(1'b0, adr(0, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, MASK_ANALOG);
        $display("test lock_bit done");
    endtask : t_lock
    task automatic t_fuse();
        do_reset(1'b1);
        bus(1'b1, adr(1, ALIAS_PLAIN), 32'h0000_0007);
        set_lock(1'b1);
        set_lock(1'b0);
        lock_is(1'b1);
        bus(1'b1, adr(1, ALIAS_CLR), 32'h0000_0007);
        bus(1'b0, adr(1, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, 32'h0000_0007);
        gate(1, 32'h0000_0007);
        do_reset(1'b1);
        lock_is(1'b0);
        bus(1'b0, adr(1, ALIAS_PLAIN), 32'h0000_0000);
        chk(rd, RESET_VAL);
        $display("test fuse_lock done");
    endtask : t_fuse
    initial begin
        rst <= 1'b1;
        clk_en <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 16'h0000;
        avs_writedata <= 32'h0000_0000;
        avs_byteenable <= 4'hf;
        config_word_three <= 32'h0000_0000;
        t_reset();
        t_plain();
        t_alias();
        t_lock();
        t_fuse();
        summarize();
    end
endmodule : testbench
`default_nettype wire
